// *** src/rtc_sram_clock.sv ***
module rtc_sram_clock #(
    parameter int SECOND_CYCLES = rtc_pkg::SECOND_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sel_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [14:0] byte_index_i,
    input wire logic [7:0] bidir_byte_lines_i,
    output logic [7:0] bidir_byte_lines_o,
    output logic bidir_byte_lines_oe_o,
    input wire logic power_fail_i,
    input wire logic battery_switch_i,
    output logic on_battery_o
);
    logic rst_m_r, rst_n_r;
    rtc_pkg::rtc_bus_s bus_m_r, bus_r, bus_d_r;
    logic pf_m_r, pf_r, bat_m_r, bat_r;
    logic [7:0] mem [rtc_pkg::MEM_DEPTH];
    rtc_pkg::rtc_time_s cnt_r, cnt_nxt, shadow_r;
    logic [7:0] ctrl_r;
    logic [31:0] tick_r;
    logic [7:0] dout_r;
    logic [1:0] idx_age_r, sel_age_r, oe_age_r;
    logic rd_act, wr_act, wr_edge, wr_bit_fall, is_time, valid_now;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // days in month, bcd; year 00 counts as leap, correct through 2099
    function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] yb;
        yb = 8'(y[7:4] * 4'ha) + {4'h0, y[3:0]};
        unique case (m)
            8'h02: month_len = (yb[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // async bus levels pass two flops before any logic sees them
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bus_m_r <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, idx: 15'h0000, din: 8'h00};
            bus_r <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, idx: 15'h0000, din: 8'h00};
            bus_d_r <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, idx: 15'h0000, din: 8'h00};
            pf_m_r <= 1'b1;
            pf_r <= 1'b1;
            bat_m_r <= 1'b0;
            bat_r <= 1'b0;
        end else begin
            bus_m_r <= '{sel_n: sel_n_i, oe_n: oe_n_i, we_n: we_n_i,
                         idx: byte_index_i, din: bidir_byte_lines_i};
            bus_r <= bus_m_r;
            bus_d_r <= bus_r;
            pf_m_r <= power_fail_i;
            pf_r <= pf_m_r;
            bat_m_r <= battery_switch_i;
            bat_r <= bat_m_r;
        end
    end

    assign rd_act = !pf_r && !bus_r.sel_n && bus_r.we_n;
    assign wr_act = !pf_r && !bus_r.sel_n && !bus_r.we_n;
    // a write is committed at its end, the earlier rising edge of select or strobe
    assign wr_edge = !pf_r && !bus_d_r.sel_n && !bus_d_r.we_n
                     && (bus_r.sel_n || bus_r.we_n);
    assign is_time = bus_d_r.idx >= rtc_pkg::CTRL_IDX;
    assign wr_bit_fall = wr_edge && bus_d_r.idx == rtc_pkg::CTRL_IDX
                         && ctrl_r[rtc_pkg::CTRL_WRITE_BIT]
                         && !bus_d_r.din[rtc_pkg::CTRL_WRITE_BIT];
    assign on_battery_o = bat_r;

    // ordinary storage; time bytes are served from the shadow instead
    always_ff @(posedge clk_i) begin
        if (wr_edge && !is_time) begin
            mem[bus_d_r.idx] <= bus_d_r.din;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= rtc_pkg::CTRL_RESET;
        end else if (wr_edge && bus_d_r.idx == rtc_pkg::CTRL_IDX) begin
            ctrl_r <= bus_d_r.din;
        end
    end

    // counters keep running on battery; only the supply, not this logic, switches
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tick_r <= 32'h0000_0000;
        end else if (tick_r == 32'(SECOND_CYCLES - 1)) begin
            tick_r <= 32'h0000_0000;
        end else begin
            tick_r <= tick_r + 32'h0000_0001;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_r.sec != rtc_pkg::SEC_MAX) begin
            cnt_nxt.sec = bcd_inc(cnt_r.sec);
        end else begin
            cnt_nxt.sec = rtc_pkg::ZERO_BCD;
            if (cnt_r.min != rtc_pkg::SEC_MAX) begin
                cnt_nxt.min = bcd_inc(cnt_r.min);
            end else begin
                cnt_nxt.min = rtc_pkg::ZERO_BCD;
                if (cnt_r.hour != rtc_pkg::HOUR_MAX) begin
                    cnt_nxt.hour = bcd_inc(cnt_r.hour);
                end else begin
                    cnt_nxt.hour = rtc_pkg::ZERO_BCD;
                    cnt_nxt.dow = (cnt_r.dow == rtc_pkg::DOW_MAX) ? rtc_pkg::ONE_BCD
                                  : bcd_inc(cnt_r.dow);
                    if (cnt_r.date < month_len(cnt_r.month, cnt_r.year)) begin
                        cnt_nxt.date = bcd_inc(cnt_r.date);
                    end else begin
                        cnt_nxt.date = rtc_pkg::ONE_BCD;
                        if (cnt_r.month != rtc_pkg::MONTH_MAX) begin
                            cnt_nxt.month = bcd_inc(cnt_r.month);
                        end else begin
                            cnt_nxt.month = rtc_pkg::ONE_BCD;
                            cnt_nxt.year = (cnt_r.year == rtc_pkg::YEAR_MAX)
                                           ? rtc_pkg::ZERO_BCD : bcd_inc(cnt_r.year);
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= '{year: 8'h00, month: 8'h01, date: 8'h01, dow: 8'h01,
                       hour: 8'h00, min: 8'h00, sec: 8'h00};
        end else if (wr_bit_fall) begin
            cnt_r <= shadow_r; // load counters when the write bit clears
        end else if (tick_r == 32'(SECOND_CYCLES - 1)) begin
            cnt_r <= cnt_nxt;
        end
    end

    // whole shadow copied in one edge; the copy stops while the write or read bit is set, so set the read bit to read several bytes
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            shadow_r <= '{year: 8'h00, month: 8'h01, date: 8'h01, dow: 8'h01,
                          hour: 8'h00, min: 8'h00, sec: 8'h00};
        end else if (wr_edge && is_time && bus_d_r.idx != rtc_pkg::CTRL_IDX) begin
            unique case (bus_d_r.idx)
                rtc_pkg::SEC_IDX: shadow_r.sec <= bus_d_r.din;
                rtc_pkg::MIN_IDX: shadow_r.min <= bus_d_r.din;
                rtc_pkg::HOUR_IDX: shadow_r.hour <= bus_d_r.din;
                rtc_pkg::DOW_IDX: shadow_r.dow <= bus_d_r.din;
                rtc_pkg::DATE_IDX: shadow_r.date <= bus_d_r.din;
                rtc_pkg::MONTH_IDX: shadow_r.month <= bus_d_r.din;
                default: shadow_r.year <= bus_d_r.din;
            endcase
        end else if (!ctrl_r[rtc_pkg::CTRL_WRITE_BIT] && !ctrl_r[rtc_pkg::CTRL_READ_BIT]) begin
            shadow_r <= cnt_r;
        end
    end

    // ages since index, select and outdrive became stable, saturating at 3
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            idx_age_r <= 2'h0;
            sel_age_r <= 2'h0;
            oe_age_r <= 2'h0;
        end else begin
            idx_age_r <= (bus_r.idx != bus_d_r.idx) ? 2'h0
                         : (idx_age_r == 2'h3 ? 2'h3 : idx_age_r + 2'h1);
            sel_age_r <= bus_r.sel_n ? 2'h0 : (sel_age_r == 2'h3 ? 2'h3 : sel_age_r + 2'h1);
            oe_age_r <= bus_r.oe_n ? 2'h0 : (oe_age_r == 2'h3 ? 2'h3 : oe_age_r + 2'h1);
        end
    end

    assign valid_now = 32'(idx_age_r) >= rtc_pkg::INDEX_TO_VALID_CYC - 1
                       && 32'(sel_age_r) >= rtc_pkg::SELECT_TO_VALID_CYC - 1
                       && 32'(oe_age_r) >= rtc_pkg::OUTDRIVE_TO_VALID_CYC - 1;

    // data flop updates only once every access time is met; before that the old
    // byte stays on the lines, which covers the index-change hold time
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dout_r <= 8'h00;
        end else if (rd_act && valid_now) begin
            unique case (bus_r.idx)
                rtc_pkg::CTRL_IDX: dout_r <= ctrl_r;
                rtc_pkg::SEC_IDX: dout_r <= shadow_r.sec;
                rtc_pkg::MIN_IDX: dout_r <= shadow_r.min;
                rtc_pkg::HOUR_IDX: dout_r <= shadow_r.hour;
                rtc_pkg::DOW_IDX: dout_r <= shadow_r.dow;
                rtc_pkg::DATE_IDX: dout_r <= shadow_r.date;
                rtc_pkg::MONTH_IDX: dout_r <= shadow_r.month;
                rtc_pkg::YEAR_IDX: dout_r <= shadow_r.year;
                default: dout_r <= mem[bus_r.idx];
            endcase
        end
    end

    // enable drops in the same cycle that select or outdrive rise as seen in bus_r
    assign bidir_byte_lines_o = dout_r;
    assign bidir_byte_lines_oe_o = rd_act && !bus_r.oe_n && !wr_act;
endmodule

// *** src/rtc_pkg.sv ***
package rtc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 32768;
    // timekeeping byte indices
    localparam logic [14:0] CTRL_IDX = 15'h7ff8;
    localparam logic [14:0] SEC_IDX = 15'h7ff9;
    localparam logic [14:0] MIN_IDX = 15'h7ffa;
    localparam logic [14:0] HOUR_IDX = 15'h7ffb;
    localparam logic [14:0] DOW_IDX = 15'h7ffc;
    localparam logic [14:0] DATE_IDX = 15'h7ffd;
    localparam logic [14:0] MONTH_IDX = 15'h7ffe;
    localparam logic [14:0] YEAR_IDX = 15'h7fff;
    // control byte fields
    localparam int CTRL_WRITE_BIT = 7;
    localparam int CTRL_READ_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // bcd limits and reset values
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DOW_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] ONE_BCD = 8'h01;
    localparam logic [7:0] ZERO_BCD = 8'h00;
    // timing in ns and clock rate
    localparam int CLK_NS = 50;
    localparam int CLK_HZ = 20000000;
    localparam int INDEX_TO_VALID_NS = 70;
    localparam int SELECT_TO_VALID_NS = 70;
    localparam int OUTDRIVE_TO_VALID_NS = 35;
    localparam int INDEX_CHANGE_HOLD_NS = 10;
    localparam int SELECT_RELEASE_FLOAT_NS = 25;
    localparam int OUTDRIVE_RELEASE_FLOAT_NS = 25;
    // least times round up, longest times round down, never below one
    localparam int INDEX_TO_VALID_CYC = (INDEX_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int SELECT_TO_VALID_CYC = (SELECT_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int OUTDRIVE_TO_VALID_CYC = (OUTDRIVE_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int INDEX_CHANGE_HOLD_CYC = (INDEX_CHANGE_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RELEASE_CYC = 1;
    localparam int SECOND_CYC = CLK_HZ;
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtc_time_s;
    typedef struct packed {
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic [14:0] idx;
        logic [7:0] din;
    } rtc_bus_s;
endpackage

// *** verification/rtc_sram_clock_properties.sv ***
module rtc_sram_clock_properties (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sel_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic bidir_byte_lines_oe_o,
    input wire logic power_fail_i,
    input wire logic battery_switch_i,
    input wire logic on_battery_o
);
    wire rd = !sel_n_i && !oe_n_i && we_n_i && !power_fail_i;
    wire oe = bidir_byte_lines_oe_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_drive; rd [*3] |-> oe; endproperty
    a_drive: assert property (p_drive) else $error("no drive in read");
    property p_rise; $rose(oe) |-> $past(rd, 2); endproperty
    a_rise: assert property (p_rise) else $error("drive outside read");
    property p_release; !rd |-> ##2 !oe; endproperty
    a_release: assert property (p_release) else $error("drive held");
    property p_sel_float; $rose(sel_n_i) |-> ##[1:2] !oe; endproperty
    a_sel_float: assert property (p_sel_float) else $error("late float");
    property p_oe_float; $rose(oe_n_i) |-> ##[1:2] !oe; endproperty
    a_oe_float: assert property (p_oe_float) else $error("late float");
    property p_write_quiet; !sel_n_i && !we_n_i |-> ##2 !oe; endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("drive in write");
    property p_fail_quiet; power_fail_i [*2] |-> ##1 !oe; endproperty
    a_fail_quiet: assert property (p_fail_quiet) else $error("drive in fail");
    property p_battery; battery_switch_i [*3] |-> on_battery_o; endproperty
    a_battery: assert property (p_battery) else $error("no battery flag");
    c_read: cover property (rd [*6]);
    c_write: cover property ((!sel_n_i && !we_n_i) [*5]);
    c_fail: cover property (power_fail_i && !sel_n_i);
endmodule
bind rtc_sram_clock rtc_sram_clock_properties chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .sel_n_i(sel_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i),
    .bidir_byte_lines_oe_o(bidir_byte_lines_oe_o), .power_fail_i(power_fail_i),
    .battery_switch_i(battery_switch_i), .on_battery_o(on_battery_o));

// *** verification/rtc_host_model.sv ***
module rtc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_i,
    input wire logic drv_i,
    output rtc_pkg::rtc_bus_s bus_o,
    output logic [7:0] line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hdrv = 1'b0;
    logic [7:0] last_r = 8'h00;
    initial bus_o = {3'b111, 15'h0000, 8'h00};
    // a floating line toggles, so a stale byte never passes for data
    assign line_o = drv_i ? dev_i : hdrv ? bus_o.din : ~last_r;
    always @(posedge clk_i) last_r <= line_o;
    task automatic wr(input logic [14:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        bus_o <= {3'b010, idx, d};
        hdrv <= 1'b1;
        repeat (5) @(posedge clk_i);
        bus_o.sel_n <= 1'b1;
        bus_o.we_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        hdrv <= 1'b0;
    endtask
    task automatic rd(input logic [14:0] idx, input int gap, output logic [7:0] d,
        output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        bus_o <= {3'b001, idx, 8'h00};
        // skip the tail of a previous read's drive before looking
        repeat (3) @(negedge clk_i);
        while (!drv_i && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        // index age reaches its limit two edges after drive, data flop one edge later
        repeat (3 + gap) @(negedge clk_i);
        d = line_o;
        ok = drv_i;
        @(posedge clk_i);
        bus_o.sel_n <= 1'b1;
        bus_o.oe_n <= 1'b1;
    endtask
endmodule

// *** verification/rtc_sram_clock_tb.sv ***
module rtc_sram_clock_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEC = 40;
    localparam int CASES[4] = '{31231, 40228, 10228, 50430};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic power_fail_i = 1'b0;
    logic battery_switch_i = 1'b0;
    logic dq_oe;
    logic on_battery_o;
    logic [7:0] dq_o;
    logic [7:0] dq_i;
    rtc_pkg::rtc_bus_s bus;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] ref_mem[int];
    always #25 clk_i = ~clk_i;
    rtc_host_model host (.clk_i(clk_i), .dev_i(dq_o), .drv_i(dq_oe), .bus_o(bus), .line_o(dq_i));
    rtc_sram_clock #(.SECOND_CYCLES(SEC)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .sel_n_i(bus.sel_n), .oe_n_i(bus.oe_n), .we_n_i(bus.we_n), .byte_index_i(bus.idx),
        .bidir_byte_lines_i(dq_i), .bidir_byte_lines_o(dq_o), .bidir_byte_lines_oe_o(dq_oe),
        .power_fail_i(power_fail_i), .battery_switch_i(battery_switch_i),
        .on_battery_o(on_battery_o));
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [14:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd(idx, $urandom_range(2), d, ok);
        if (ok !== 1'b1) begin
            failures++;
            end_sim();
        end
        chk(d, exp);
    endtask
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    initial begin
        int y, m, d;
        logic [14:0] a;
        logic [7:0] v;
        logic ok;
        rtc_pkg::rtc_time_s t;
        void'($urandom(87));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdc(rtc_pkg::CTRL_IDX, rtc_pkg::CTRL_RESET);
        for (int i = 0; i < 8; i++) begin
            a = i == 0 ? 15'h0000 : i == 1 ? 15'h7ff7 : 15'($urandom_range(32759));
            ref_mem[a] = 8'($urandom);
            host.wr(a, ref_mem[a]);
        end
        foreach (ref_mem[k]) rdc(15'(k), ref_mem[k]);
        $display("storage test done");
        power_fail_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        host.wr(15'h0000, ~ref_mem[0]);
        host.rd(15'h0000, 0, v, ok);
        chk({7'h00, ok}, 8'h00);
        power_fail_i <= 1'b0;
        battery_switch_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h00, on_battery_o}, 8'h01);
        battery_switch_i <= 1'b0;
        rdc(15'h0000, ref_mem[0]);
        $display("power test done");
        foreach (CASES[i]) begin
            y = CASES[i] / 10000;
            m = CASES[i] / 100 % 100;
            d = CASES[i] % 100;
            t = {bcd(y), bcd(m), bcd(d), 32'h07235959};
            host.wr(rtc_pkg::CTRL_IDX, 8'h85);
            for (int j = 0; j < 7; j++) host.wr(rtc_pkg::SEC_IDX + 15'(j), t[8 * j +: 8]);
            host.wr(rtc_pkg::CTRL_IDX, 8'h05);
            // at least one tick lands; a second one only moves seconds to 01
            repeat (SEC + SEC / 4) @(posedge clk_i);
            host.wr(rtc_pkg::CTRL_IDX, 8'h45);
            v = 8'(m == 2 ? 28 + (y % 4 == 0) : m == 4 || m == 6 || m == 9 || m == 11 ? 30 : 31);
            d = d < v ? d + 1 : 1;
            m = d > 1 ? m : m % 12 + 1;
            y = d > 1 || m > 1 ? y : y + 1;
            t = {bcd(y), bcd(m), bcd(d), 32'h01000000};
            for (int j = 1; j < 7; j++) rdc(rtc_pkg::SEC_IDX + 15'(j), t[8 * j +: 8]);
            host.rd(rtc_pkg::SEC_IDX, 0, v, ok);
            chk({7'h00, v > 8'h01}, 8'h00);
            rdc(rtc_pkg::CTRL_IDX, 8'h45);
        end
        $display("calendar test done");
        end_sim();
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        end_sim();
    end
endmodule
